// *** hw/obc_pkg.sv ***
// package for the output buffer configuration register bank
package obc_pkg;

	// ****************************************************************
	// register map and widths
	// ****************************************************************
	localparam int OBC_AW = 8;
	localparam int OBC_DW = 16;
	localparam logic [7:0] OBC_OFS_LEVEL_A = 8'h04;
	localparam logic [7:0] OBC_OFS_LEVEL_B = 8'h05;
	localparam logic [7:0] OBC_OFS_FRAME_CM = 8'h06;

	// ****************************************************************
	// reset values and writable masks
	// ****************************************************************
	localparam logic [15:0] OBC_RST_LEVEL_A = 16'h360f;
	localparam logic [15:0] OBC_RST_LEVEL_B = 16'h4936;
	localparam logic [15:0] OBC_RST_FRAME_CM = 16'h36d6;
	localparam logic [15:0] OBC_MASK_LEVEL_A = 16'h3fff;
	localparam logic [15:0] OBC_MASK_LEVEL_B = 16'h7fff;
	localparam logic [15:0] OBC_MASK_FRAME_CM = 16'hffff;

	// ****************************************************************
	// field positions
	// ****************************************************************
	localparam int OBC_HF_ON_LSB = 0;
	localparam int OBC_FRAME_ON_LSB = 4;
	localparam int OBC_HF0_LVL_LSB = 8;
	localparam int OBC_HF1_LVL_LSB = 11;
	localparam int OBC_HF2_LVL_LSB = 0;
	localparam int OBC_HF3_LVL_LSB = 3;
	localparam int OBC_FR0_LVL_LSB = 6;
	localparam int OBC_FR1_LVL_LSB = 9;
	localparam int OBC_FR2_LVL_LSB = 12;
	localparam int OBC_FR3_LVL_LSB = 0;
	localparam int OBC_FR0_CM_LSB = 3;
	localparam int OBC_FR1_CM_LSB = 6;
	localparam int OBC_FR2_CM_LSB = 9;
	localparam int OBC_FR3_CM_LSB = 12;
	localparam int OBC_FABRIC_ON_BIT = 15;

	// settings handed to the analog drivers
	typedef struct packed {
		logic [3:0] hf_on;
		logic [3:0] frame_on;
		logic [3:0][2:0] hf_level;
		logic [3:0][2:0] frame_level;
		logic [3:0][2:0] frame_cm;
		logic fabric_on;
	} obc_drv_t;

endpackage

// *** hw/obc_regs.sv ***
// output buffer configuration register bank with driver setting outputs
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// (R01) four clock buffer enables sit in bits 3:0 at 0x4 and reset to one.
// (R02) four frame buffer enables sit in bits 7:4 at 0x4 and reset to zero.
// (R03) each clock output has a 3-bit level resetting to 6 at 0x4 and 0x5.
// (R04) each frame output has a 3-bit level at 0x5 and 0x6, resetting to 4 except frame 3 at 6.
// (R05) each frame output has a 3-bit common-mode field at 0x6, resetting to 3 except frame 0 at 2.
// (R06) bit 15 at 0x6 enables the fabric clock buffer and resets to zero.
// (R07) software picks frame level and common mode together to stay in limits.
// (R08) the words reset to 0x360f, 0x4936 and 0x36d6.
// (R09) unused upper bits read zero and ignore writes; fields hold until written or reset.
module obc_regs
	import obc_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// register port
	input wire logic [OBC_AW-1:0] reg_addr,
	input wire logic [OBC_DW-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [OBC_DW-1:0] reg_rdata,
	// driver settings
	output obc_drv_t drv
);

	// ****************************************************************
	// storage
	// ****************************************************************
	logic [15:0] level_a_r;
	logic [15:0] level_b_r;
	logic [15:0] frame_cm_r;
	logic [15:0] rdata_r;
	obc_drv_t drv_r;

	function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] wd,
		input logic [15:0] mask);
		merge = (old & ~mask) | (wd & mask);
	endfunction

	wire sel_a = reg_addr == OBC_OFS_LEVEL_A;
	wire sel_b = reg_addr == OBC_OFS_LEVEL_B;
	wire sel_c = reg_addr == OBC_OFS_FRAME_CM;
	wire [15:0] level_a_nxt = (reg_wr && sel_a) ?
		merge(level_a_r, reg_wdata, OBC_MASK_LEVEL_A) : level_a_r; // see (R09)
	wire [15:0] level_b_nxt = (reg_wr && sel_b) ?
		merge(level_b_r, reg_wdata, OBC_MASK_LEVEL_B) : level_b_r; // see (R09)
	wire [15:0] frame_cm_nxt = (reg_wr && sel_c) ?
		merge(frame_cm_r, reg_wdata, OBC_MASK_FRAME_CM) : frame_cm_r;
	// unmapped addresses read as zero
	wire [15:0] rd_sel = sel_a ? level_a_r : sel_b ? level_b_r : sel_c ? frame_cm_r : 16'h0000;
	wire [15:0] rdata_nxt = reg_rd ? rd_sel : 16'h0000;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			level_a_r <= OBC_RST_LEVEL_A; // see (R08)
			level_b_r <= OBC_RST_LEVEL_B; // see (R08)
			frame_cm_r <= OBC_RST_FRAME_CM; // see (R08)
			rdata_r <= 16'h0000;
		end else begin
			level_a_r <= level_a_nxt;
			level_b_r <= level_b_nxt;
			frame_cm_r <= frame_cm_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	// ****************************************************************
	// field extraction toward the drivers
	// ****************************************************************
	// one decoder serves the live path and the reset value, so the drivers
	// leave reset with the same settings that the registers hold
	function automatic obc_drv_t decode_drv(input logic [15:0] wa, input logic [15:0] wb,
		input logic [15:0] wc);
		obc_drv_t d;
		d.hf_on = wa[OBC_HF_ON_LSB +: 4]; // see (R01)
		d.frame_on = wa[OBC_FRAME_ON_LSB +: 4]; // see (R02)
		d.hf_level[0] = wa[OBC_HF0_LVL_LSB +: 3]; // see (R03)
		d.hf_level[1] = wa[OBC_HF1_LVL_LSB +: 3]; // see (R03)
		d.hf_level[2] = wb[OBC_HF2_LVL_LSB +: 3]; // see (R03)
		d.hf_level[3] = wb[OBC_HF3_LVL_LSB +: 3]; // see (R03)
		d.frame_level[0] = wb[OBC_FR0_LVL_LSB +: 3]; // see (R04)
		d.frame_level[1] = wb[OBC_FR1_LVL_LSB +: 3]; // see (R04)
		d.frame_level[2] = wb[OBC_FR2_LVL_LSB +: 3]; // see (R04)
		d.frame_level[3] = wc[OBC_FR3_LVL_LSB +: 3]; // see (R04)
		// level and common mode are passed as written, no limit check: see (R07)
		d.frame_cm[0] = wc[OBC_FR0_CM_LSB +: 3]; // see (R05)
		d.frame_cm[1] = wc[OBC_FR1_CM_LSB +: 3]; // see (R05)
		d.frame_cm[2] = wc[OBC_FR2_CM_LSB +: 3]; // see (R05)
		d.frame_cm[3] = wc[OBC_FR3_CM_LSB +: 3]; // see (R05)
		d.fabric_on = wc[OBC_FABRIC_ON_BIT]; // see (R06)
		return d;
	endfunction

	// settings are registered once more so every output leaves a flip-flop;
	// the drivers therefore see a write one cycle after the register does
	obc_drv_t drv_nxt;
	assign drv_nxt = decode_drv(level_a_r, level_b_r, frame_cm_r);

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			drv_r <= decode_drv(OBC_RST_LEVEL_A, OBC_RST_LEVEL_B, OBC_RST_FRAME_CM); // see (R01)
		end else begin
			drv_r <= drv_nxt;
		end
	end

	assign reg_rdata = rdata_r;
	assign drv = drv_r;

	// ****************************************************************
	// assertions
	// ****************************************************************
	sequence s_wr_a;
		reg_wr && sel_a;
	endsequence

	sequence s_wr_b;
		reg_wr && sel_b;
	endsequence

	sequence s_wr_c;
		reg_wr && sel_c;
	endsequence

	property p_hf_on_reset;
		@(posedge clk) $fell(sys_rst) |-> drv.hf_on == 4'hf;
	endproperty
	a_hf_on_reset: assert property (p_hf_on_reset) else $error("clock enables not on after reset"); // see (R01)

	property p_frame_on_follow;
		@(posedge clk) disable iff (sys_rst)
			s_wr_a ##1 !sys_rst |-> ##1 drv.frame_on == $past(reg_wdata[7:4], 2);
	endproperty
	a_frame_on_follow: assert property (p_frame_on_follow) else $error("frame enable mismatch"); // see (R02)

	property p_hf_level_follow;
		@(posedge clk) disable iff (sys_rst)
			reg_wr && sel_b ##1 !sys_rst |-> ##1 drv.hf_level[2] == $past(reg_wdata[2:0], 2);
	endproperty
	a_hf_level_follow: assert property (p_hf_level_follow) else $error("clock level mismatch"); // see (R03)

	property p_frame_level3;
		@(posedge clk) disable iff (sys_rst)
			reg_wr && sel_c ##1 !sys_rst |-> ##1 drv.frame_level[3] == $past(reg_wdata[2:0], 2);
	endproperty
	a_frame_level3: assert property (p_frame_level3) else $error("frame level 3 mismatch"); // see (R04)

	property p_frame_cm_follow;
		@(posedge clk) disable iff (sys_rst)
			reg_wr && sel_c ##1 !sys_rst |-> ##1 drv.frame_cm[3] == $past(reg_wdata[14:12], 2);
	endproperty
	a_frame_cm_follow: assert property (p_frame_cm_follow) else $error("common mode mismatch"); // see (R05)

	property p_fabric_on;
		@(posedge clk) disable iff (sys_rst)
			s_wr_c ##1 !sys_rst |-> ##1 drv.fabric_on == $past(reg_wdata[15], 2);
	endproperty
	a_fabric_on: assert property (p_fabric_on) else $error("fabric enable mismatch"); // see (R06)

	property p_read_reset;
		@(posedge clk) $fell(sys_rst) && reg_rd && sel_b |=> reg_rdata == OBC_RST_LEVEL_B;
	endproperty
	a_read_reset: assert property (p_read_reset) else $error("level b reset value wrong"); // see (R08)

	property p_unused_zero;
		@(posedge clk) disable iff (sys_rst)
			reg_rd |=> reg_rdata[15:14] == 2'b00 || $past(sel_c) || ($past(sel_b) && !reg_rdata[15]);
	endproperty
	a_unused_zero: assert property (p_unused_zero) else $error("unused bits not zero"); // see (R09)

	// ****************************************************************
	// field paths, reset words and holding
	// ****************************************************************
	property p_hf_on_follow;
		@(posedge clk) disable iff (sys_rst)
			s_wr_a ##1 !sys_rst |-> ##1 drv.hf_on == $past(reg_wdata[3:0], 2);
	endproperty
	a_hf_on_follow: assert property (p_hf_on_follow) // see (R01)
		else $error("clock enable mismatch");

	property p_hf_level_a;
		@(posedge clk) disable iff (sys_rst)
			s_wr_a ##1 !sys_rst |-> ##1 drv.hf_level[1] == $past(reg_wdata[13:11], 2)
			&& drv.hf_level[0] == $past(reg_wdata[10:8], 2);
	endproperty
	a_hf_level_a: assert property (p_hf_level_a) // see (R03)
		else $error("clock level 0 or 1 mismatch");

	property p_hf_level3;
		@(posedge clk) disable iff (sys_rst)
			s_wr_b ##1 !sys_rst |-> ##1 drv.hf_level[3] == $past(reg_wdata[5:3], 2);
	endproperty
	a_hf_level3: assert property (p_hf_level3) // see (R03)
		else $error("clock level 3 mismatch");

	property p_frame_level_b;
		@(posedge clk) disable iff (sys_rst)
			s_wr_b ##1 !sys_rst |-> ##1 drv.frame_level[2] == $past(reg_wdata[14:12], 2)
			&& drv.frame_level[1] == $past(reg_wdata[11:9], 2)
			&& drv.frame_level[0] == $past(reg_wdata[8:6], 2);
	endproperty
	a_frame_level_b: assert property (p_frame_level_b) // see (R04)
		else $error("frame level 0 to 2 mismatch");

	property p_frame_cm_low;
		@(posedge clk) disable iff (sys_rst)
			s_wr_c ##1 !sys_rst |-> ##1 drv.frame_cm[2] == $past(reg_wdata[11:9], 2)
			&& drv.frame_cm[1] == $past(reg_wdata[8:6], 2)
			&& drv.frame_cm[0] == $past(reg_wdata[5:3], 2);
	endproperty
	a_frame_cm_low: assert property (p_frame_cm_low) // see (R05)
		else $error("common mode 0 to 2 mismatch");

	// reset is synchronous, so the words are checked one edge after it is seen
	property p_reset_words;
		@(posedge clk) sys_rst |=> level_a_r == OBC_RST_LEVEL_A
			&& level_b_r == OBC_RST_LEVEL_B && frame_cm_r == OBC_RST_FRAME_CM;
	endproperty
	a_reset_words: assert property (p_reset_words) // see (R08)
		else $error("register reset word wrong");

	property p_drv_reset;
		@(posedge clk) sys_rst |=> drv.frame_on == 4'h0 && !drv.fabric_on;
	endproperty
	a_drv_reset: assert property (p_drv_reset) // see (R02)
		else $error("frame or fabric buffer on in reset");

	property p_reserved_zero;
		@(posedge clk) disable iff (sys_rst)
			level_a_r[15:14] == 2'b00 && !level_b_r[15];
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) // see (R09)
		else $error("reserved bit stored");

	property p_hold;
		@(posedge clk) disable iff (sys_rst)
			!reg_wr |=> $stable(level_a_r) && $stable(level_b_r) && $stable(frame_cm_r);
	endproperty
	a_hold: assert property (p_hold) // see (R09)
		else $error("register changed without a write");

endmodule
`default_nettype wire

// *** tb/obc_regs_test.sv ***
// self-checking bench for the output buffer configuration register bank
`timescale 1ns/1ps
`default_nettype none
module obc_regs_test;
	import obc_pkg::*;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [OBC_AW-1:0] reg_addr = '0;
	logic [OBC_DW-1:0] reg_wdata = '0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [OBC_DW-1:0] reg_rdata;
	obc_drv_t drv;
	logic [15:0] mdl [4:7];
	int err_total = 0;
	int n_checks = 0;
	int cyc = 0;
	integer seed = 32'h8685;
	always #2.5 clk = ~clk;
	obc_regs DUT (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .drv(drv));
	// ****************************************************************
	// expectation model
	// ****************************************************************
	function logic [15:0] wmask(input logic [7:0] a);
		case (a)
			8'h04: return 16'h3fff;
			8'h05: return 16'h7fff;
			8'h06: return 16'hffff;
			default: return 16'h0000;
		endcase
	endfunction
	function obc_drv_t exp_drv();
		obc_drv_t d;
		d.hf_on = mdl[4][3:0];
		d.frame_on = mdl[4][7:4];
		d.hf_level = {mdl[5][5:3], mdl[5][2:0], mdl[4][13:11], mdl[4][10:8]};
		d.frame_level = {mdl[6][2:0], mdl[5][14:12], mdl[5][11:9], mdl[5][8:6]};
		d.frame_cm = {mdl[6][14:12], mdl[6][11:9], mdl[6][8:6], mdl[6][5:3]};
		d.fabric_on = mdl[6][15];
		return d;
	endfunction
	task mdl_reset();
		mdl[4] = 16'h360f;
		mdl[5] = 16'h4936;
		mdl[6] = 16'h36d6;
		mdl[7] = 16'h0000;
	endtask
	task chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// ****************************************************************
	// bus tasks
	// ****************************************************************
	task op(input logic w, input logic r, input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_wr <= w;
		reg_rd <= r;
		reg_addr <= a;
		reg_wdata <= d;
	endtask
	task wr(input logic [7:0] a, input logic [15:0] d);
		op(1'b1, 1'b0, a, d);
		if (a >= 8'h04 && a <= 8'h07) mdl[a] = d & wmask(a);
	endtask
	// unmapped places model as zero, so one expression covers both
	task rd(input logic [7:0] a);
		op(1'b0, 1'b1, a, 16'h0000);
		op(1'b0, 1'b0, a, 16'h0000);
		#1 chk("reg_rdata", reg_rdata, (a >= 8'h04 && a <= 8'h07) ? mdl[a] : 16'h0000);
	endtask
	// drv lags a write by two edges, so two idle cycles pass first
	task idle_chk();
		op(1'b0, 1'b0, reg_addr, 16'h0000);
		op(1'b0, 1'b0, reg_addr, 16'h0000);
		#1 chk("reg_rdata idle", reg_rdata, 64'h0);
		chk("drv", 64'(drv), 64'(exp_drv()));
	endtask
	task print_verdict();
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc = cyc + 1;
		if (cyc == 5000) begin
			err_total++;
			print_verdict();
		end
	end
	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial begin
		logic [7:0] a;
		mdl_reset();
		repeat (10) @(posedge clk);
		sys_rst <= 1'b0;
		op(1'b0, 1'b0, 8'h00, 16'h0000);
		idle_chk();
		for (int i = 0; i < 8; i++) rd(8'(i));
		for (int i = 4; i < 8; i++) begin
			wr(8'(i), 16'hffff);
			rd(8'(i));
			wr(8'(i), 16'h0000);
			rd(8'(i));
			idle_chk();
		end
		// random level and common-mode pairs test storage and driver paths only; software must pair them
		repeat (60) begin
			a = 8'($random(seed) & 7);
			wr(a, 16'($random(seed)));
			rd(a);
			idle_chk();
		end
		@(posedge clk);
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk);
		mdl_reset();
		// the read strobe rises with the release, so the first cycle out of reset takes it
		op(1'b0, 1'b1, OBC_OFS_LEVEL_B, 16'h0000);
		sys_rst <= 1'b0;
		op(1'b0, 1'b0, 8'h00, 16'h0000);
		#1 chk("reg_rdata first", reg_rdata, 64'(OBC_RST_LEVEL_B));
		idle_chk();
		for (int i = 4; i < 7; i++) rd(8'(i));
		print_verdict();
	end
endmodule
`default_nettype wire
